/* rtc_cmos_config_regs_consts.vh */
`ifndef RTC_CMOS_CONFIG_REGS_CONSTS_VH
`define RTC_CMOS_CONFIG_REGS_CONSTS_VH

// Register indices; byte address is index times four
`define IDX_BANK_ACTIVATE      8'h30
`define IDX_BANK0_BASE_HIGH    8'h60
`define IDX_BANK0_BASE_LOW     8'h61
`define IDX_BANK1_BASE_HIGH    8'h62
`define IDX_BANK1_BASE_LOW     8'h63
`define IDX_BANK1_REGION_LOCK  8'hf0
`define IDX_BANK0_INDEX_SHADOW 8'hf1

// Field layout
`define ACT_BANK0_BIT          0
`define ACT_BANK1_BIT          1
`define ACT_MASK               8'h03
`define HIGH_MASK              8'h0f
`define LOW_MASK               8'hfe
`define LOCK_MASK              4'hf
`define LOCK_REGION_MSB        6
`define LOCK_REGION_LSB        5

// Reset values
`define RST_BANK_ACTIVATE      8'h00
`define RST_BASE_HIGH          8'h00
`define RST_BANK0_BASE_LOW     8'h70
`define RST_BANK1_BASE_LOW     8'h74
`define RST_STANDBY_BASE_LOW   8'h00
`define RST_LOCK               4'h0
`define RST_SHADOW             8'h00

// Value returned for a denied CMOS read
`define DENIED_READ_DATA       8'hff

`endif

/* rtc_cmos_config_regs.v */
// Functional notes
// - Activate bits enable bank 0, bank 1
// - High byte holds base bits 11 to 8
// - Low byte holds bits 7 to 1, bit0 zero
// - Low bytes 70h/74h; standby POR loads zero
// - Lock bits set by writing one only
// - Locks clear on POR, power loss, PCI reset
// - Deny host access to locked regions
// - Shadow returns last bank 0 index write
`include "rtc_cmos_config_regs_consts.vh"

module rtc_cmos_config_regs (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        pce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        standby_por,
   input  wire        pci_reset,
   input  wire        soft_reset,
   input  wire        main_power_good,
   input  wire        index_wr,
   input  wire [7:0]  index_wr_data,
   input  wire        host_req,
   input  wire        host_write,
   input  wire [6:0]  host_addr,
   input  wire [7:0]  cmos_rdata,
   output wire        bank0_enable,
   output wire        bank1_enable,
   output wire [11:0] bank0_base,
   output wire [11:0] bank1_base,
   output wire        cmos_we,
   output wire [7:0]  host_rdata,
   output wire        host_denied
);

   reg  [3:0]  sync1_reg;
   reg  [3:0]  sync2_reg;
   wire        standby_por_s;
   wire        pci_reset_s;
   wire        soft_reset_s;
   wire        power_good_s;

   reg  [7:0]  activate_reg;
   reg  [7:0]  b0_high_reg;
   reg  [7:0]  b0_low_reg;
   reg  [7:0]  b1_high_reg;
   reg  [7:0]  b1_low_reg;
   reg  [3:0]  lock_reg;
   reg  [7:0]  shadow_reg;

   reg  [7:0]  activate_next;
   reg  [7:0]  b0_high_next;
   reg  [7:0]  b0_low_next;
   reg  [7:0]  b1_high_next;
   reg  [7:0]  b1_low_next;
   reg  [3:0]  lock_next;

   reg  [31:0] prdata_reg;
   reg         pready_reg;
   reg         pslverr_reg;
   reg         cmos_we_reg;
   reg  [7:0]  host_rdata_reg;
   reg         host_denied_reg;

   wire        aligned;
   wire [7:0]  index;
   wire        commit;
   wire        wr_commit;
   wire        lane0;
   reg  [7:0]  rd_byte;
   reg         hit;
   wire        region_locked;
   wire        cfg_reset;
   wire        lock_clear;
   wire        host_locked;
   wire        access_cycle;
   wire        bus_error;

   // Pins from other domains pass two flops first
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else if (pce) begin
         sync1_reg <= {main_power_good, soft_reset, pci_reset, standby_por};
         sync2_reg <= sync1_reg;
      end
   end

   assign standby_por_s = sync2_reg[0];
   assign pci_reset_s   = sync2_reg[1];
   assign soft_reset_s  = sync2_reg[2];
   assign power_good_s  = sync2_reg[3];

   // APB decode: index is word address
   assign aligned   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
   assign index     = paddr[9:2];
   assign commit    = psel && penable && pready_reg;
   assign wr_commit = commit && pwrite && hit && !pslverr_reg;
   assign lane0     = pstrb[0];

   always @* begin
      hit     = aligned;
      rd_byte = 8'h00;
      case (index)
         `IDX_BANK_ACTIVATE:      rd_byte = activate_reg;
         `IDX_BANK0_BASE_HIGH:    rd_byte = b0_high_reg;
         `IDX_BANK0_BASE_LOW:     rd_byte = b0_low_reg;
         `IDX_BANK1_BASE_HIGH:    rd_byte = b1_high_reg;
         `IDX_BANK1_BASE_LOW:     rd_byte = b1_low_reg;
         `IDX_BANK1_REGION_LOCK:  rd_byte = {4'h0, lock_reg};
         `IDX_BANK0_INDEX_SHADOW: rd_byte = shadow_reg;
         default:                 hit = 1'b0;
      endcase
      if (!aligned) begin
         rd_byte = 8'h00;
      end
   end

   // Register write path; reserved bits forced to zero
   always @* begin
      activate_next = activate_reg;
      b0_high_next  = b0_high_reg;
      b0_low_next   = b0_low_reg;
      b1_high_next  = b1_high_reg;
      b1_low_next   = b1_low_reg;
      lock_next     = lock_reg;
      if (wr_commit && lane0) begin
         case (index)
            `IDX_BANK_ACTIVATE:     activate_next = pwdata[7:0] & `ACT_MASK;
            `IDX_BANK0_BASE_HIGH:   b0_high_next = pwdata[7:0] & `HIGH_MASK;
            `IDX_BANK0_BASE_LOW:    b0_low_next = pwdata[7:0] & `LOW_MASK;
            `IDX_BANK1_BASE_HIGH:   b1_high_next = pwdata[7:0] & `HIGH_MASK;
            `IDX_BANK1_BASE_LOW:    b1_low_next = pwdata[7:0] & `LOW_MASK;
            `IDX_BANK1_REGION_LOCK: lock_next = lock_reg | (pwdata[3:0] & `LOCK_MASK);
            default:                lock_next = lock_reg;
         endcase
      end
   end

   // PCI and soft resets load the same defaults
   assign cfg_reset  = pci_reset_s || soft_reset_s;
   // Soft reset is not a lock clear source
   assign lock_clear = standby_por_s || pci_reset_s || !power_good_s;

   // Activation bits clear on every reset source
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         activate_reg <= `RST_BANK_ACTIVATE;
      end else if (pce) begin
         if (standby_por_s || cfg_reset) begin
            activate_reg <= `RST_BANK_ACTIVATE;
         end else begin
            activate_reg <= activate_next;
         end
      end
   end

   // High bytes clear on every reset source
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b0_high_reg <= `RST_BASE_HIGH;
         b1_high_reg <= `RST_BASE_HIGH;
      end else if (pce) begin
         if (standby_por_s || cfg_reset) begin
            b0_high_reg <= `RST_BASE_HIGH;
            b1_high_reg <= `RST_BASE_HIGH;
         end else begin
            b0_high_reg <= b0_high_next;
            b1_high_reg <= b1_high_next;
         end
      end
   end

   // Low bytes: standby loss zeroes them, other resets load defaults
   // A reset beats a same-cycle write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b0_low_reg <= `RST_BANK0_BASE_LOW;
         b1_low_reg <= `RST_BANK1_BASE_LOW;
      end else if (pce) begin
         if (standby_por_s) begin
            b0_low_reg <= `RST_STANDBY_BASE_LOW;
            b1_low_reg <= `RST_STANDBY_BASE_LOW;
         end else if (cfg_reset) begin
            b0_low_reg <= `RST_BANK0_BASE_LOW;
            b1_low_reg <= `RST_BANK1_BASE_LOW;
         end else begin
            b0_low_reg <= b0_low_next;
            b1_low_reg <= b1_low_next;
         end
      end
   end

   // Locks survive soft reset only
   // A clear beats a same-cycle set, so no write can dodge a reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_reg <= `RST_LOCK;
      end else if (pce) begin
         if (lock_clear) begin
            lock_reg <= `RST_LOCK;
         end else begin
            lock_reg <= lock_next;
         end
      end
   end

   // Shadow follows every index write on the bank 0 port
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow_reg <= `RST_SHADOW;
      end else if (pce && index_wr) begin
         shadow_reg <= index_wr_data;
      end
   end

   // One wait state: answer on the second access cycle
   assign access_cycle = psel && penable;
   assign bus_error    = !hit || (pwrite && index == `IDX_BANK0_INDEX_SHADOW);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else if (pce) begin
         pready_reg <= access_cycle && !pready_reg;
      end
   end

   // Error pulses with ready, never on its own
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else if (pce) begin
         pslverr_reg <= access_cycle && !pready_reg && bus_error;
      end
   end

   // Read data changes only at the answer; writes and errors read zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else if (pce && access_cycle && !pready_reg) begin
         prdata_reg <= (pwrite || bus_error) ? 32'h00000000 : {24'h000000, rd_byte};
      end
   end

   // Region select from offset bits 6:5
   assign region_locked = lock_reg[host_addr[`LOCK_REGION_MSB:`LOCK_REGION_LSB]];
   // Locks only bite while main power is up
   assign host_locked   = region_locked && power_good_s;

   // Denial flag pulses once per refused request
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_denied_reg <= 1'b0;
      end else if (pce) begin
         host_denied_reg <= host_req && host_locked;
      end
   end

   // Write strobe also needs bank 1 active to reach the array
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmos_we_reg <= 1'b0;
      end else if (pce) begin
         cmos_we_reg <= host_req && host_write && !host_locked && activate_reg[`ACT_BANK1_BIT];
      end
   end

   // Read data holds until the next read; a locked read shows all ones
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_rdata_reg <= `DENIED_READ_DATA;
      end else if (pce && host_req && !host_write) begin
         host_rdata_reg <= host_locked ? `DENIED_READ_DATA : cmos_rdata;
      end
   end

   assign prdata       = prdata_reg;
   assign pready       = pready_reg;
   assign pslverr      = pslverr_reg;
   assign bank0_enable = activate_reg[`ACT_BANK0_BIT];
   assign bank1_enable = activate_reg[`ACT_BANK1_BIT];
   assign bank0_base   = {b0_high_reg[3:0], b0_low_reg};
   assign bank1_base   = {b1_high_reg[3:0], b1_low_reg};
   assign cmos_we      = cmos_we_reg;
   assign host_rdata   = host_rdata_reg;
   assign host_denied  = host_denied_reg;

endmodule

/* rtc_cmos_config_regs_chk.sv */
module rtc_cmos_config_regs_chk (
   input logic        pclk,
   input logic        presetn,
   input logic        pce,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0]  pstrb,
   input logic        pready,
   input logic        pslverr,
   input logic        host_req,
   input logic        host_write,
   input logic        bank0_enable,
   input logic        bank1_enable,
   input logic [11:0] bank0_base,
   input logic [11:0] bank1_base,
   input logic        cmos_we,
   input logic [7:0]  host_rdata,
   input logic        host_denied
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence wr_ack(a);
      pce && psel && penable && pready && pwrite && pstrb[0] && paddr == a;
   endsequence
   chk_base_aligned: assert property (bank0_base[0] == 1'b0 && bank1_base[0] == 1'b0)
      else $error("base bit 0 set");
   chk_low_write: assert property (wr_ack(12'h18c) |=> bank1_base[7:0] == ($past(pwdata[7:0]) & 8'hfe))
      else $error("bank1 low byte wrong");
   chk_high_write: assert property (wr_ack(12'h180) |=> bank0_base[11:8] == $past(pwdata[3:0]))
      else $error("bank0 high byte wrong");
   chk_act_write: assert property (wr_ack(12'h0c0) |=> {bank1_enable, bank0_enable} == $past(pwdata[1:0]))
      else $error("activate bits wrong");
   chk_reset_bases: assert property ($rose(presetn) |-> bank0_base == 12'h070 && bank1_base == 12'h074)
      else $error("base reset value wrong");
   chk_denied_nowe: assert property (host_denied |-> !cmos_we)
      else $error("write strobe on denied access");
   chk_denied_read: assert property (host_denied && !$past(host_write) |-> host_rdata == 8'hff)
      else $error("locked read leaked data");
   chk_we_cause: assert property (cmos_we |-> $past(host_req) && $past(host_write))
      else $error("write strobe without host write");
   chk_shadow_ro: assert property (pready && psel && pwrite && paddr == 12'h3c4 |-> pslverr)
      else $error("shadow write not refused");
   cov_lock_wr: cover property (wr_ack(12'h3c0));
   cov_denied: cover property (host_denied);
   cov_we: cover property (cmos_we);
endmodule

bind rtc_cmos_config_regs rtc_cmos_config_regs_chk i_chk (
   .pclk         (pclk),
   .presetn      (presetn),
   .pce          (pce),
   .psel         (psel),
   .penable      (penable),
   .pwrite       (pwrite),
   .paddr        (paddr),
   .pwdata       (pwdata),
   .pstrb        (pstrb),
   .pready       (pready),
   .pslverr      (pslverr),
   .host_req     (host_req),
   .host_write   (host_write),
   .bank0_enable (bank0_enable),
   .bank1_enable (bank1_enable),
   .bank0_base   (bank0_base),
   .bank1_base   (bank1_base),
   .cmos_we      (cmos_we),
   .host_rdata   (host_rdata),
   .host_denied  (host_denied)
);

/* tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, pce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        standby_por = 1'b0, pci_reset = 1'b0, soft_reset = 1'b0, main_power_good = 1'b1;
   logic        index_wr = 1'b0, host_req = 1'b0, host_write = 1'b0;
   logic        pready, pslverr, bank0_enable, bank1_enable, cmos_we, host_denied, err, we, den;
   logic [11:0] paddr = 12'h000, bank0_base, bank1_base, a;
   logic [31:0] pwdata = 32'h0, prdata, rd, d;
   logic [3:0]  pstrb = 4'hf;
   logic [7:0]  index_wr_data = 8'h00, cmos_rdata = 8'h00, host_rdata, hd, v;
   logic [6:0]  host_addr = 7'h00;
   logic [4:0]  o;
   logic [11:0] regs [6] = '{12'h0c0, 12'h180, 12'h184, 12'h188, 12'h18c, 12'h3c0};
   logic [7:0]  defs [6] = '{8'h00, 8'h00, 8'h70, 8'h00, 8'h74, 8'h00};
   int          bad_count = 0, check_count = 0;
   rtc_cmos_config_regs i_dut (
      .pclk            (pclk),
      .presetn         (presetn),
      .pce             (pce),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .pstrb           (pstrb),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .standby_por     (standby_por),
      .pci_reset       (pci_reset),
      .soft_reset      (soft_reset),
      .main_power_good (main_power_good),
      .index_wr        (index_wr),
      .index_wr_data   (index_wr_data),
      .host_req        (host_req),
      .host_write      (host_write),
      .host_addr       (host_addr),
      .cmos_rdata      (cmos_rdata),
      .bank0_enable    (bank0_enable),
      .bank1_enable    (bank1_enable),
      .bank0_base      (bank0_base),
      .bank1_base      (bank1_base),
      .cmos_we         (cmos_we),
      .host_rdata      (host_rdata),
      .host_denied     (host_denied)
   );
   always #20 pclk = ~pclk;
   function automatic logic [31:0] exp_rd(input logic [11:0] ad, input logic [7:0] x);
      case (ad)
         12'h0c0: return {24'h0, x & 8'h03};
         12'h180, 12'h188: return {24'h0, x & 8'h0f};
         default: return {24'h0, x & 8'hfe};
      endcase
   endfunction
   task test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Waits are bounded; a stuck slave ends the run
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] x);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= x;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         chk("pready", 32'h1, 32'h0);
         test_done;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task host(input logic w, input logic [6:0] ad);
      @(posedge pclk);
      host_req <= 1'b1;
      host_write <= w;
      host_addr <= ad;
      cmos_rdata <= v;
      @(posedge pclk);
      host_req <= 1'b0;
      @(posedge pclk);
      we = cmos_we;
      den = host_denied;
      hd = host_rdata;
   endtask
   initial begin
      rd = $urandom(32'hf85953b6);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, regs[i], 32'h0);
         chk("reset value", {24'h0, defs[i]}, rd);
      end
      $display("test reset values done");
      for (int i = 0; i < 40; i++) begin
         a = regs[$urandom_range(4)];
         d = $urandom;
         apb(1'b1, a, d);
         apb(1'b0, a, 32'h0);
         chk("readback", exp_rd(a, d[7:0]), rd);
      end
      // Write with byte lane 0 off must be ignored
      apb(1'b1, 12'h180, 32'h5);
      pstrb <= 4'he;
      apb(1'b1, 12'h180, 32'ha);
      pstrb <= 4'hf;
      apb(1'b0, 12'h180, 32'h0);
      chk("lane0 strobe", 32'h5, rd);
      $display("test random writes done");
      apb(1'b0, 12'h004, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(1'b1, 12'h3c4, d);
      chk("shadow write err", 32'h1, {31'h0, err});
      for (int i = 0; i < 3; i++) begin
         v = $urandom;
         @(posedge pclk);
         index_wr <= 1'b1;
         index_wr_data <= v;
         @(posedge pclk);
         index_wr <= 1'b0;
         apb(1'b0, 12'h3c4, 32'h0);
         chk("shadow", {24'h0, v}, rd);
      end
      // Clock enable low freezes the shadow
      @(posedge pclk);
      pce <= 1'b0;
      index_wr <= 1'b1;
      index_wr_data <= ~v;
      @(posedge pclk);
      pce <= 1'b1;
      index_wr <= 1'b0;
      apb(1'b0, 12'h3c4, 32'h0);
      chk("shadow frozen", {24'h0, v}, rd);
      $display("test shadow done");
      apb(1'b1, 12'h0c0, 32'h3);
      apb(1'b1, 12'h3c0, 32'h5);
      apb(1'b1, 12'h3c0, 32'h0);
      apb(1'b0, 12'h3c0, 32'h0);
      chk("lock sticky", 32'h5, rd);
      // Regions 0 and 2 locked, 1 and 3 open
      for (int r = 0; r < 4; r++) begin
         v = $urandom;
         o = $urandom;
         host(1'b1, {r[1:0], o});
         chk("host denied", {31'h0, ~r[0]}, {31'h0, den});
         chk("host we", {31'h0, r[0]}, {31'h0, we});
         host(1'b0, {r[1:0], o});
         chk("host rdata", r[0] ? {24'h0, v} : 32'hff, {24'h0, hd});
      end
      apb(1'b1, 12'h3c0, 32'ha);
      apb(1'b0, 12'h3c0, 32'h0);
      chk("lock set", 32'hf, rd);
      $display("test locks done");
      @(posedge pclk) soft_reset <= 1'b1;
      repeat (2) @(posedge pclk);
      soft_reset <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h3c0, 32'h0);
      chk("lock after soft", 32'hf, rd);
      apb(1'b0, 12'h184, 32'h0);
      chk("low after soft", 32'h70, rd);
      @(posedge pclk) pci_reset <= 1'b1;
      repeat (2) @(posedge pclk);
      pci_reset <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h3c0, 32'h0);
      chk("lock after pci", 32'h0, rd);
      apb(1'b1, 12'h3c0, 32'hf);
      @(posedge pclk) main_power_good <= 1'b0;
      repeat (3) @(posedge pclk);
      main_power_good <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h3c0, 32'h0);
      chk("lock after power loss", 32'h0, rd);
      @(posedge pclk) standby_por <= 1'b1;
      repeat (2) @(posedge pclk);
      standby_por <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, 12'h184, 32'h0);
      chk("low after standby", 32'h0, rd);
      apb(1'b0, 12'h18c, 32'h0);
      chk("low after standby", 32'h0, rd);
      chk("base1 after standby", 32'h0, {20'h0, bank1_base});
      $display("test pin resets done");
      test_done;
   end
endmodule
